// File: hdl/ring_map.svh
`ifndef RING_MAP_SVH
`define RING_MAP_SVH

// ----------------------------------------
// Line patterns, sent bit 0 first
// ----------------------------------------
`define RING_FLAG 8'h7e
`define RING_FILL 8'hfe
`define RING_PAT_LAST 3'h7

// ----------------------------------------
// Stuffing and timing
// ----------------------------------------
`define RING_STUFF_RUN 3'h5
`define RING_SAMPLES_PER_BIT 8
`define RING_FILL_PERIOD_BITS 16

`endif

// File: hdl/ring_pkg.sv
package ring_pkg;
  typedef enum logic [1:0] {
    ST_FILL,
    ST_OPEN,
    ST_BODY,
    ST_CLOSE
  } tx_state_t;
endpackage

// File: hdl/bit_clock_if.sv
`timescale 1ns/100ps
interface bit_clock_if;
  logic tick;
  logic rxBit;
  logic freeRun;
  modport recover (output tick, output rxBit, input freeRun);
  modport framer (input tick, input rxBit, output freeRun);
endinterface

// File: hdl/bit_clock_recovery.sv
`timescale 1ns/100ps
`include "ring_map.svh"
module bit_clock_recovery import ring_pkg::*; #(
  parameter int SPB = `RING_SAMPLES_PER_BIT
) (
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic rxSync,
  bit_clock_if.recover bc
);

  localparam int PW = $clog2(SPB);
  localparam logic [PW-1:0] PH_LAST = PW'(SPB - 1);
  localparam logic [PW-1:0] PH_MID = PW'(SPB / 2);

  logic [PW-1:0] phase_ff;
  logic [PW-1:0] nxt_phase;
  logic rxPrev_ff;
  logic rxBit_ff;
  logic tick_ff;

  // ----------------------------------------
  // Phase tracking
  // ----------------------------------------
  // Each received transition restarts the phase so the sample point sits
  // mid-bit; a master runs free and ignores the incoming stream.
  wire rxEdge = (rxSync != rxPrev_ff) && !bc.freeRun;
  wire phaseWrap = (phase_ff == PH_LAST);
  assign nxt_phase = rxEdge ? PW'(1) : (phaseWrap ? '0 : phase_ff + PW'(1));
  wire sampleNow = (phase_ff == PH_MID);

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      phase_ff <= '0;
      rxPrev_ff <= 1'b0;
      rxBit_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      rxPrev_ff <= rxSync;
      tick_ff <= sampleNow;
      if (sampleNow) begin
        rxBit_ff <= rxSync;
      end
    end
  end

  assign bc.tick = tick_ff;
  assign bc.rxBit = rxBit_ff;
endmodule

// File: hdl/ring_telegram_fill_repeater.sv
`timescale 1ns/100ps
`include "ring_map.svh"
module ring_telegram_fill_repeater import ring_pkg::*; #(
  parameter int SPB = `RING_SAMPLES_PER_BIT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic masterPin,
  input wire logic rxLine,
  input wire logic txStart,
  input wire logic bitValid,
  input wire logic bitData,
  input wire logic bitLast,
  output logic bitReady,
  output logic txLine,
  output logic busy,
  output logic bitTick
);

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  // Release is synchronous so every flop on rstSyncN leaves reset on the same edge
  logic rstMeta_ff;
  logic rstSyncN_ff;
  logic modeMeta_ff;
  logic isMaster_ff;
  logic rxMeta_ff;
  logic rxSync_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_ff <= 1'b0;
      rstSyncN_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSyncN_ff <= rstMeta_ff;
    end
  end

  wire rstSyncN = rstSyncN_ff;

  // Mode pin and line are asynchronous to clk and pass two flops
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeMeta_ff <= 1'b0;
      isMaster_ff <= 1'b0;
      rxMeta_ff <= 1'b0;
      rxSync_ff <= 1'b0;
    end else begin
      modeMeta_ff <= masterPin;
      isMaster_ff <= modeMeta_ff;
      rxMeta_ff <= rxLine;
      rxSync_ff <= rxMeta_ff;
    end
  end

  // ----------------------------------------
  // Bit clock
  // ----------------------------------------
  bit_clock_if bc ();

  // A master has no upstream clock, so the same counter runs free
  assign bc.freeRun = isMaster_ff;

  bit_clock_recovery #(.SPB(SPB)) u_recover (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .rxSync(rxSync_ff),
    .bc(bc)
  );

  // ----------------------------------------
  // Framing state
  // ----------------------------------------
  tx_state_t state_ff;
  tx_state_t nxt_state;
  logic [2:0] patIdx_ff;
  logic [2:0] nxt_patIdx;
  logic [2:0] ones_ff;
  logic [2:0] nxt_ones;
  logic lastSeen_ff;
  logic nxt_lastSeen;
  logic startPend_ff;
  logic line_ff;
  logic txBit;
  logic useRepeat;
  logic take;

  // Both words go out bit 0 first
  localparam logic [7:0] FLAG = `RING_FLAG;
  localparam logic [7:0] FILL = `RING_FILL;

  // All framing state except startPend_ff moves on the bit tick only
  wire tick = bc.tick;
  wire stuffDue = (ones_ff == `RING_STUFF_RUN);
  wire bodyEnds = lastSeen_ff || !bitValid;
  wire patDone = (patIdx_ff == `RING_PAT_LAST);
  wire inFill = (state_ff == ST_FILL);

  always_comb begin
    nxt_state = state_ff;
    nxt_patIdx = patIdx_ff + 3'h1;
    nxt_ones = ones_ff;
    nxt_lastSeen = lastSeen_ff;
    txBit = 1'b1;
    useRepeat = 1'b0;
    take = 1'b0;
    case (state_ff)
      ST_FILL: begin
        txBit = FILL[patIdx_ff];
        useRepeat = !isMaster_ff;
        // A pending start leaves fill only on a tick, never mid-bit
        if (startPend_ff) begin
          nxt_state = ST_OPEN;
          nxt_patIdx = 3'h0;
        end
      end
      ST_OPEN: begin
        txBit = FLAG[patIdx_ff];
        // Limitation: the first body bit must be valid on the next tick
        if (patDone) begin
          nxt_state = ST_BODY;
          nxt_ones = 3'h0;
          nxt_lastSeen = 1'b0;
        end
      end
      ST_BODY: begin
        // Stuffing also runs after the last body bit, ahead of the close
        if (stuffDue) begin
          txBit = 1'b0;
          nxt_ones = 3'h0;
        end else if (bodyEnds) begin
          // A missing bit ends the telegram rather than corrupting it
          txBit = FLAG[0];
          nxt_state = ST_CLOSE;
          nxt_patIdx = 3'h1;
        end else begin
          txBit = bitData;
          take = 1'b1;
          nxt_lastSeen = bitLast;
          nxt_ones = bitData ? ones_ff + 3'h1 : 3'h0;
        end
      end
      ST_CLOSE: begin
        // Fill restarts at its zero bit once the close is out
        txBit = FLAG[patIdx_ff];
        if (patDone) begin
          nxt_state = ST_FILL;
          nxt_patIdx = 3'h0;
        end
      end
      default: begin
        nxt_state = ST_FILL;
        nxt_patIdx = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_ff <= ST_FILL;
      patIdx_ff <= 3'h0;
      ones_ff <= 3'h0;
      lastSeen_ff <= 1'b0;
    end else if (tick) begin
      state_ff <= nxt_state;
      patIdx_ff <= nxt_patIdx;
      ones_ff <= nxt_ones;
      lastSeen_ff <= nxt_lastSeen;
    end
  end

  // ----------------------------------------
  // Start request
  // ----------------------------------------
  // Request arriving on the tick that consumes the previous one is kept
  wire startTaken = tick && inFill;
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      startPend_ff <= 1'b0;
    end else if (txStart) begin
      startPend_ff <= 1'b1;
    end else if (startTaken) begin
      startPend_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Line coder
  // ----------------------------------------
  // Every change, coded or repeated, lands on a tick only, so the hand-over
  // between telegram, fill and repeat needs no special case.
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      line_ff <= 1'b0;
    end else if (tick) begin
      // Only the mid-bit sample is repeated, so glitches are not passed on
      if (useRepeat) begin
        line_ff <= bc.rxBit;
      end else if (!txBit) begin
        line_ff <= !line_ff;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign txLine = line_ff;
  assign bitReady = tick && take;
  assign busy = startPend_ff || !inFill;
  assign bitTick = tick;
endmodule

// File: test/ring_peer.sv
`timescale 1ns/100ps
// ----
// Far node: slow sender and NRZI receiver
// ----
module ring_peer (
  input wire logic clk,
  input wire logic tick,
  input wire logic txLine,
  input wire logic clr,
  output logic rxLine,
  output logic [7:0] flags,
  output logic [7:0] maxRun
);
  logic [1:0] td;
  logic lvl;
  logic [3:0] div;
  logic [7:0] sr;
  logic [7:0] run;
  wire b = txLine == lvl;
  wire [7:0] nsr = {b, sr[7:1]};
  initial begin
    {td, lvl, div, sr, run, rxLine, flags, maxRun} = '0;
  end
  always @(posedge clk) begin
    div <= div + 4'h1;
    if (div == 4'hf) rxLine <= !rxLine;
    // Decode two clocks after the tick, clear of the update edge
    td <= {td[0], tick};
    if (td[1]) begin
      lvl <= txLine;
      sr <= nsr;
      run <= b ? run + 8'h01 : 8'h00;
    end
    if (clr) begin
      flags <= 8'h00;
      maxRun <= 8'h00;
    end else if (td[1]) begin
      if (nsr == 8'h7e) flags <= flags + 8'h01;
      if (b && run >= maxRun) maxRun <= run + 8'h01;
    end
  end
endmodule

// File: test/ring_telegram_chk.sv
`timescale 1ns/100ps
module ring_telegram_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic txStart,
  input wire logic bitData,
  input wire logic bitReady,
  input wire logic txLine,
  input wire logic busy,
  input wire logic bitTick
);
  logic [2:0] ones_ff;
  wire gap = bitTick && !bitReady;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ones_ff <= 3'h0;
    else if (gap || (bitReady && !bitData)) ones_ff <= 3'h0;
    else if (bitReady) ones_ff <= ones_ff + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sAsk; txStart && !busy; endsequence
  sequence sGo; busy [*8]; endsequence
  a_line_on_tick: assert property (
    $changed(txLine) |-> bitTick || $past(bitTick)) else $error("edge");
  a_take_on_tick: assert property (
    bitReady |-> bitTick) else $error("take");
  a_take_busy: assert property (
    bitReady |-> busy) else $error("idle take");
  a_ones_run: assert property (
    ones_ff <= 3'h5) else $error("no stuff");
  a_tick_pulse: assert property (
    bitTick |=> !bitTick) else $error("tick");
  a_tick_alive: assert property (
    bitTick |-> ##[1:16] bitTick) else $error("no tick");
  a_busy_fall: assert property (
    $fell(busy) |-> $past(bitTick)) else $error("fall");
  a_start_busy: assert property (
    sAsk |=> sGo) else $error("start");
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, rstn, masterPin, txStart, bitValid, bitData, bitLast, clr;
  logic rxLine, bitReady, txLine, busy, bitTick;
  logic [7:0] flags, maxRun;
  int errors;
  int check_count;
  ring_telegram_fill_repeater #(.SPB(4)) uut (.clk, .rstn, .masterPin,
    .rxLine, .txStart, .bitValid, .bitData, .bitLast, .bitReady,
    .txLine, .busy, .bitTick);
  ring_peer peer (.clk, .tick(bitTick), .txLine, .clr, .rxLine, .flags,
    .maxRun);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_fill;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256) @(posedge clk);
    check(maxRun, 8'h07);
    check(flags, 8'h00);
  endtask
  // Telegram of twelve ones: forces two stuffed zeros
  task automatic t_tele;
    int n;
    int k;
    n = 0;
    txStart <= 1'b1;
    @(posedge clk);
    txStart <= 1'b0;
    bitValid <= 1'b1;
    bitData <= 1'b1;
    repeat (6) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    for (k = 0; k < 4000 && busy === 1'b1; k++) begin
      @(posedge clk);
      bitLast <= (n >= 11);
      bitValid <= (n < 12);
      #1;
      if (bitReady === 1'b1) n++;
    end
    if (k == 4000) begin
      errors++;
      complete_run;
    end
    bitLast <= 1'b0;
    repeat (8) @(posedge clk);
    check(flags, 8'h02);
    check(maxRun, 8'h06);
    check(8'(n), 8'h0c);
  endtask
  // Telegram cut short: bitValid falls after five body ones
  task automatic t_short;
    int n;
    int k;
    n = 0;
    txStart <= 1'b1;
    bitValid <= 1'b1;
    bitData <= 1'b1;
    @(posedge clk);
    txStart <= 1'b0;
    repeat (6) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    for (k = 0; k < 4000 && busy === 1'b1; k++) begin
      @(posedge clk);
      bitValid <= (n < 5);
      #1;
      if (bitReady === 1'b1) n++;
    end
    if (k == 4000) begin
      errors++;
      complete_run;
    end
    repeat (8) @(posedge clk);
    check(flags, 8'h02);
    check(maxRun, 8'h06);
    check(8'(n), 8'h05);
  endtask
  task automatic t_slave;
    int cr;
    int ct;
    logic pr;
    logic pt;
    cr = 0;
    ct = 0;
    masterPin <= 1'b0;
    repeat (16) @(posedge clk);
    #1;
    pr = rxLine;
    pt = txLine;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (rxLine !== pr) cr++;
      if (txLine !== pt) ct++;
      pr = rxLine;
      pt = txLine;
    end
    check({7'h00, 8'(cr - ct + 1) <= 8'h02}, 8'h01);
  endtask
  initial begin
    {rstn, txStart, bitValid, bitData, bitLast, clr} = '0;
    masterPin = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_fill;
    t_tele;
    t_short;
    t_slave;
    t_tele;
    complete_run;
  end
endmodule
bind ring_telegram_fill_repeater ring_telegram_chk chk (.clk, .rstn,
  .txStart, .bitData, .bitReady, .txLine, .busy, .bitTick);
